/* File: hw/pxb_pkg.sv */
// constants for the port cell and crossbar assigner
package pxb_pkg;
    // ==========================================
    // pin geometry
    localparam int          NPIN      = 40;
    localparam int          NSKIP     = 32;
    localparam int          PIN_W     = 6;
    localparam int          NRES      = 24;
    localparam int          PORT_W    = 8;
    // ==========================================
    // fixed pins
    localparam logic [5:0]  PIN_UART_TX = 6'h04;
    localparam logic [5:0]  PIN_UART_RX = 6'h05;
    localparam logic [5:0]  PIN_CAN_TX  = 6'h06;
    localparam logic [5:0]  PIN_CAN_RX  = 6'h07;
    localparam logic [5:0]  PIN_DBG     = 6'h20;
    localparam logic [5:0]  PIN_P1_BASE = 6'h08;
    // ==========================================
    // resources in priority order
    localparam int RES_UART_TX = 0;
    localparam int RES_UART_RX = 1;
    localparam int RES_CAN_TX  = 2;
    localparam int RES_CAN_RX  = 3;
    localparam int RES_SS_CLK  = 4;
    localparam int RES_SS_SEL  = 7;
    localparam int RES_TW_DAT  = 8;
    localparam int RES_TW_CLK  = 9;
    localparam int RES_CMP0    = 10;
    localparam int RES_SYSCLK  = 14;
    localparam int RES_CEX0    = 15;
    localparam int RES_ECI     = 21;
    localparam int RES_T0      = 22;
    localparam int RES_T1      = 23;
    // ==========================================
    // select register fields
    localparam int SEL_A_UART   = 0;
    localparam int SEL_A_SS     = 1;
    localparam int SEL_A_TW     = 2;
    localparam int SEL_A_CMP0   = 3;
    localparam int SEL_A_SYSCLK = 7;
    localparam int SEL_B_CEX_LO = 0;
    localparam int SEL_B_ECI    = 3;
    localparam int SEL_B_T0     = 4;
    localparam int SEL_B_T1     = 5;
    localparam int SEL_C_CAN    = 0;
    // ==========================================
    // external interrupt config fields
    localparam int IRQ0_SEL_LO = 0;
    localparam int IRQ0_POL    = 3;
    localparam int IRQ1_SEL_LO = 4;
    localparam int IRQ1_POL    = 7;
    // ==========================================
    // reset values
    localparam logic [NPIN-1:0] READ_RST = '0;
endpackage

/* File: hw/pxb_pad_cell.sv */
// one port cell: drive style, pull-up and receiver gating
`timescale 1ns/10ps
module pxb_pad_cell
(
    input  wire logic dig_i,
    input  wire logic push_pull_i,
    input  wire logic val_i,
    input  wire logic drive_i,
    input  wire logic xbar_en_i,
    input  wire logic pu_gdis_i,
    output logic      oe_o,
    output logic      out_o,
    output logic      pu_o,
    output logic      rx_en_o
);
    logic act;
    logic low;

    always_comb
    begin
        act     = xbar_en_i & dig_i & drive_i;
        oe_o    = act & (push_pull_i | ~val_i);
        out_o   = act & push_pull_i & val_i;
        low     = oe_o & ~out_o;
        pu_o    = dig_i & ~low & ~pu_gdis_i;
        rx_en_o = dig_i;
    end
endmodule

/* File: hw/pxb_port_xbar.sv */
// port input/output block with priority crossbar and event capture
// ==========================================
// Contract
// - pads float with pull-up until crossbar enabled, except P4.0 while debug wire data output is enabled
// - analog pin: pull-up, driver, receiver off
// - analog pin always reads zero
// - digital pin picks push-pull or open-drain
// - push-pull drives both levels
// - open-drain drives low only
// - pull-up on when released, off driving low
// - global disable kills all pull-ups
// - digital read returns pad level
// - latch read independent of crossbar routing
// - three select registers choose routed peripherals
// - skipped pins never claimed, except fixed serial and can pins
// - only unskipped pins assignable, fixed serial and can pins aside
// - serial and can on fixed pins
// - port four has no skip bits
// - port four carries digital functions only
// - pin levels raise interrupt or match, rise of any event raises wake
// - capture on digital pins, never analog
// - P4.0 shared with debug wire data
// - lowest free unskipped pin per resource
`timescale 1ns/10ps
module pxb_port_xbar
    import pxb_pkg::*;
(
    input  wire logic                      sys_clk_i,
    input  wire logic                      reset_n_i,
    input  wire logic                      crossbar_enable_bit_i,
    input  wire logic                      pullup_global_disable_i,
    input  wire logic [pxb_pkg::NPIN-1:0]  pin_input_mode_bits_i,
    input  wire logic [pxb_pkg::NPIN-1:0]  pin_output_style_bits_i,
    input  wire logic [pxb_pkg::NSKIP-1:0] pin_skip_bits_i,
    input  wire logic [pxb_pkg::NPIN-1:0]  port_latch_i,
    input  wire logic [7:0]                route_select_reg_a_i,
    input  wire logic [7:0]                route_select_reg_b_i,
    input  wire logic [7:0]                route_select_reg_c_i,
    input  wire logic [pxb_pkg::NRES-1:0]  periph_out_i,
    input  wire logic [pxb_pkg::NRES-1:0]  periph_drive_i,
    input  wire logic                      debug_wire_data_oe_i,
    input  wire logic                      debug_wire_data_out_i,
    input  wire logic [7:0]                ext_irq_pin_config_i,
    input  wire logic [pxb_pkg::NSKIP-1:0] port_compare_mask_i,
    input  wire logic [pxb_pkg::NSKIP-1:0] port_compare_value_i,
    input  wire logic [pxb_pkg::NPIN-1:0]  pad_in_i,
    output logic [pxb_pkg::NPIN-1:0]       pad_out_o,
    output logic [pxb_pkg::NPIN-1:0]       pad_oe_o,
    output logic [pxb_pkg::NPIN-1:0]       pad_pullup_o,
    output logic [pxb_pkg::NPIN-1:0]       pad_rx_en_o,
    output logic [pxb_pkg::NPIN-1:0]       port_read_o,
    output logic [pxb_pkg::NRES-1:0]       periph_in_o,
    output logic [pxb_pkg::NRES-1:0]       periph_assigned_o,
    output logic                           debug_wire_data_in_o,
    output logic                           ext_irq0_o,
    output logic                           ext_irq1_o,
    output logic                           port_match_o,
    output logic                           wake_o
);
    import pxb_pkg::*;

    // ==========================================
    // helpers
    function automatic logic [6:0] lowest_free(input logic [NPIN-1:0] taken);
        logic [6:0] r;
        r = 7'h00;
        for (int i = NPIN - 1; i >= 0; i--)
        begin
            if (!taken[i])
                r = {1'b1, 6'(i)};
        end
        return r;
    endfunction

    function automatic logic pick_bit(input logic [NPIN-1:0] v,
                                      input logic [5:0]      idx);
        return v[idx];
    endfunction

    function automatic logic [5:0] irq_pin(input logic [2:0] sel);
        return PIN_P1_BASE + {3'h0, sel};
    endfunction

    // ==========================================
    // resource enables from select registers
    logic [NRES-1:0] res_en;

    always_comb
    begin
        res_en = '0;
        res_en[RES_UART_TX] = route_select_reg_a_i[SEL_A_UART];
        res_en[RES_UART_RX] = route_select_reg_a_i[SEL_A_UART];
        res_en[RES_CAN_TX]  = route_select_reg_c_i[SEL_C_CAN];
        res_en[RES_CAN_RX]  = route_select_reg_c_i[SEL_C_CAN];
        for (int k = RES_SS_CLK; k <= RES_SS_SEL; k++)
            res_en[k] = route_select_reg_a_i[SEL_A_SS];
        res_en[RES_TW_DAT] = route_select_reg_a_i[SEL_A_TW];
        res_en[RES_TW_CLK] = route_select_reg_a_i[SEL_A_TW];
        for (int k = 0; k < 4; k++)
            res_en[RES_CMP0 + k] = route_select_reg_a_i[SEL_A_CMP0 + k];
        res_en[RES_SYSCLK] = route_select_reg_a_i[SEL_A_SYSCLK];
        for (int k = 0; k < 6; k++)
            res_en[RES_CEX0 + k] =
                (3'(k) < route_select_reg_b_i[SEL_B_CEX_LO +: 3]);
        res_en[RES_ECI] = route_select_reg_b_i[SEL_B_ECI];
        res_en[RES_T0]  = route_select_reg_b_i[SEL_B_T0];
        res_en[RES_T1]  = route_select_reg_b_i[SEL_B_T1];
    end

    // ==========================================
    // priority assigner
    logic [NRES-1:0]  asg_ok_ff;
    logic [NRES-1:0]  nxt_asg_ok;
    logic [PIN_W-1:0] asg_pin_ff [NRES];
    logic [PIN_W-1:0] nxt_asg_pin [NRES];

    always_comb
    begin
        logic [NPIN-1:0] taken;
        logic [6:0]      fr;
        taken = '0;
        fr    = 7'h00;
        taken[NSKIP-1:0] = pin_skip_bits_i;
        taken[NPIN-1:NSKIP] = '0;
        for (int r = 0; r < NRES; r++)
        begin
            nxt_asg_ok[r]  = 1'b0;
            nxt_asg_pin[r] = '0;
        end
        if (res_en[RES_UART_TX])
        begin
            nxt_asg_ok[RES_UART_TX]  = 1'b1;
            nxt_asg_pin[RES_UART_TX] = PIN_UART_TX;
            nxt_asg_ok[RES_UART_RX]  = 1'b1;
            nxt_asg_pin[RES_UART_RX] = PIN_UART_RX;
            taken[PIN_UART_TX] = 1'b1;
            taken[PIN_UART_RX] = 1'b1;
        end
        if (res_en[RES_CAN_TX])
        begin
            nxt_asg_ok[RES_CAN_TX]  = 1'b1;
            nxt_asg_pin[RES_CAN_TX] = PIN_CAN_TX;
            nxt_asg_ok[RES_CAN_RX]  = 1'b1;
            nxt_asg_pin[RES_CAN_RX] = PIN_CAN_RX;
            taken[PIN_CAN_TX] = 1'b1;
            taken[PIN_CAN_RX] = 1'b1;
        end
        for (int r = RES_SS_CLK; r < NRES; r++)
        begin
            fr = lowest_free(taken);
            if (res_en[r] && fr[6])
            begin
                nxt_asg_ok[r]  = 1'b1;
                nxt_asg_pin[r] = fr[5:0];
                taken[fr[5:0]] = 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            asg_ok_ff <= '0;
            for (int r = 0; r < NRES; r++)
                asg_pin_ff[r] <= '0;
        end
        else
        begin
            asg_ok_ff <= nxt_asg_ok;
            for (int r = 0; r < NRES; r++)
                asg_pin_ff[r] <= nxt_asg_pin[r];
        end
    end

    // ==========================================
    // per pin source selection and cells
    logic [NPIN-1:0] pin_val;
    logic [NPIN-1:0] pin_drive;
    logic [NPIN-1:0] pin_dig;
    logic [NPIN-1:0] pin_pp;
    logic [NPIN-1:0] cell_en;

    always_comb
    begin
        pin_val   = port_latch_i;
        pin_drive = '1;
        pin_dig   = pin_input_mode_bits_i;
        pin_pp    = pin_output_style_bits_i;
        cell_en   = {NPIN{crossbar_enable_bit_i}};
        for (int r = 0; r < NRES; r++)
        begin
            if (asg_ok_ff[r])
            begin
                pin_val[asg_pin_ff[r]]   = periph_out_i[r];
                pin_drive[asg_pin_ff[r]] = periph_drive_i[r];
            end
        end
        pin_dig[NPIN-1:NSKIP] = '1;
        if (debug_wire_data_oe_i)
        begin
            pin_val[PIN_DBG]   = debug_wire_data_out_i;
            pin_drive[PIN_DBG] = 1'b1;
            pin_pp[PIN_DBG]    = 1'b1;
            cell_en[PIN_DBG]   = 1'b1;
        end
    end

    for (genvar p = 0; p < NPIN; p++)
    begin : g_cell
        pxb_pad_cell u_cell
        (
            .dig_i       (pin_dig[p]),
            .push_pull_i (pin_pp[p]),
            .val_i       (pin_val[p]),
            .drive_i     (pin_drive[p]),
            .xbar_en_i   (cell_en[p]),
            .pu_gdis_i   (pullup_global_disable_i),
            .oe_o        (pad_oe_o[p]),
            .out_o       (pad_out_o[p]),
            .pu_o        (pad_pullup_o[p]),
            .rx_en_o     (pad_rx_en_o[p])
        );
    end

    // ==========================================
    // read back and peripheral inputs
    logic [NPIN-1:0] read_ff;
    logic [NPIN-1:0] nxt_read;
    logic [NRES-1:0] pin_ff;
    logic [NRES-1:0] nxt_pin;
    logic            dbg_ff;
    logic            nxt_dbg;

    always_comb
    begin
        nxt_read = pad_in_i & pin_dig;
        for (int r = 0; r < NRES; r++)
            nxt_pin[r] = asg_ok_ff[r] & pick_bit(read_ff, asg_pin_ff[r]);
        nxt_dbg = read_ff[PIN_DBG];
    end

    always_ff @(posedge sys_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            read_ff <= READ_RST;
            pin_ff  <= '0;
            dbg_ff  <= 1'b0;
        end
        else
        begin
            read_ff <= nxt_read;
            pin_ff  <= nxt_pin;
            dbg_ff  <= nxt_dbg;
        end
    end

    // ==========================================
    // event capture
    logic [2:0]      evt_ff;
    logic [2:0]      nxt_evt;
    logic            wake_ff;
    logic            nxt_wake;

    always_comb
    begin
        logic [5:0] src0;
        logic [5:0] src1;
        src0 = irq_pin(ext_irq_pin_config_i[IRQ0_SEL_LO +: 3]);
        src1 = irq_pin(ext_irq_pin_config_i[IRQ1_SEL_LO +: 3]);
        nxt_evt[0] = pin_dig[src0] &
            (ext_irq_pin_config_i[IRQ0_POL] ~^ read_ff[src0]);
        nxt_evt[1] = pin_dig[src1] &
            (ext_irq_pin_config_i[IRQ1_POL] ~^ read_ff[src1]);
        nxt_evt[2] = |((read_ff[NSKIP-1:0] ^ port_compare_value_i) &
            port_compare_mask_i & pin_dig[NSKIP-1:0]);
        nxt_wake = |(nxt_evt & ~evt_ff);
    end

    always_ff @(posedge sys_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            evt_ff  <= '0;
            wake_ff <= 1'b0;
        end
        else
        begin
            evt_ff  <= nxt_evt;
            wake_ff <= nxt_wake;
        end
    end

    assign port_read_o          = read_ff;
    assign periph_in_o          = pin_ff;
    assign periph_assigned_o    = asg_ok_ff;
    assign debug_wire_data_in_o = dbg_ff;
    assign ext_irq0_o           = evt_ff[0];
    assign ext_irq1_o           = evt_ff[1];
    assign port_match_o         = evt_ff[2];
    assign wake_o               = wake_ff;
endmodule

/* File: dv/pxb_pad_far.sv */
// far-side pad model: outside drivers, weak pull-up and floating pads
`timescale 1ns/10ps
module pxb_pad_far
(
    input  wire logic                     sys_clk_i,
    input  wire logic [pxb_pkg::NPIN-1:0] drv_val_i,
    input  wire logic [pxb_pkg::NPIN-1:0] drv_en_i,
    input  wire logic [pxb_pkg::NPIN-1:0] pull_en_i,
    input  wire logic [pxb_pkg::NPIN-1:0] ext_en_i,
    input  wire logic [pxb_pkg::NPIN-1:0] ext_val_i,
    output logic      [pxb_pkg::NPIN-1:0] pad_o
);
    import pxb_pkg::*;
    // ==========================================
    // pad resolution
    logic [NPIN-1:0] last_ff;
    // a floating pad shows the inverse of its last driven level
    always_ff @(posedge sys_clk_i)
        for (int i = 0; i < NPIN; i++)
            if (drv_en_i[i] | ext_en_i[i] | pull_en_i[i])
                last_ff[i] <= pad_o[i];
    always_comb
        for (int i = 0; i < NPIN; i++)
            pad_o[i] = drv_en_i[i] ? drv_val_i[i] :
                       ext_en_i[i] ? ext_val_i[i] :
                       pull_en_i[i] ? 1'b1 : !last_ff[i];
endmodule

/* File: dv/pxb_props.sv */
// assertions on the port cell and crossbar ports
`timescale 1ns/10ps
module pxb_props
(
    input wire logic                     sys_clk_i,
    input wire logic                     reset_n_i,
    input wire logic                     crossbar_enable_bit_i,
    input wire logic                     pullup_global_disable_i,
    input wire logic [pxb_pkg::NPIN-1:0] pin_input_mode_bits_i,
    input wire logic [pxb_pkg::NPIN-1:0] pin_output_style_bits_i,
    input wire logic [7:0]               route_select_reg_a_i,
    input wire logic                     debug_wire_data_oe_i,
    input wire logic [7:0]               ext_irq_pin_config_i,
    input wire logic [pxb_pkg::NPIN-1:0] pad_in_i,
    input wire logic [pxb_pkg::NPIN-1:0] pad_out_o,
    input wire logic [pxb_pkg::NPIN-1:0] pad_oe_o,
    input wire logic [pxb_pkg::NPIN-1:0] pad_pullup_o,
    input wire logic [pxb_pkg::NPIN-1:0] pad_rx_en_o,
    input wire logic [pxb_pkg::NPIN-1:0] port_read_o,
    input wire logic [pxb_pkg::NRES-1:0] periph_assigned_o,
    input wire logic                     ext_irq0_o,
    input wire logic                     wake_o
);
    import pxb_pkg::*;
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!reset_n_i);
    logic lvl0;
    assign lvl0 = pad_in_i[PIN_P1_BASE + 6'(ext_irq_pin_config_i[2:0])]
                  ~^ ext_irq_pin_config_i[3];
    // ==========================================
    // assertions
    AST_PRE_XBAR: assert property (
        !crossbar_enable_bit_i && !debug_wire_data_oe_i |-> pad_oe_o == '0
        && pad_pullup_o[31:0] == (pin_input_mode_bits_i[31:0]
        & {32{!pullup_global_disable_i}})) else $error("pads not idle");
    AST_ANALOG_OFF: assert property (
        !pin_input_mode_bits_i[2] |-> !pad_oe_o[2] && !pad_pullup_o[2]
        && !pad_rx_en_o[2]) else $error("analog pin active");
    AST_ANALOG_READ: assert property (
        !pin_input_mode_bits_i[2] |=> !port_read_o[2])
        else $error("analog pin read not zero");
    AST_OD_NO_HIGH: assert property (
        pin_input_mode_bits_i[9] && !pin_output_style_bits_i[9]
        |-> !(pad_oe_o[9] && pad_out_o[9])) else $error("open-drain high");
    AST_PULL_LOW: assert property (
        pad_oe_o[9] && !pad_out_o[9] |-> !pad_pullup_o[9])
        else $error("pull-up on while driving low");
    AST_GDIS: assert property (
        pullup_global_disable_i |-> pad_pullup_o == '0)
        else $error("pull-up on under global disable");
    AST_DIG_READ: assert property (
        pin_input_mode_bits_i[9] && $past(reset_n_i, 2)
        |=> port_read_o[9] == $past(pad_in_i[9])) else $error("read bad");
    AST_UART_FIXED: assert property (
        (crossbar_enable_bit_i && route_select_reg_a_i[0])[*2]
        |-> periph_assigned_o[1:0] == 2'b11) else $error("uart unassigned");
    AST_IRQ0_LEVEL: assert property (
        ($stable(ext_irq_pin_config_i) && &pin_input_mode_bits_i[15:8])[*3]
        ##0 $past(reset_n_i, 3) |-> ext_irq0_o == $past(lvl0, 2))
        else $error("irq0 level bad");
    AST_WAKE: assert property (
        $rose(ext_irq0_o) |-> ##[0:1] wake_o) else $error("no wake");
    COV_UART: cover property (periph_assigned_o[1:0] == 2'b11);
    COV_WAKE: cover property (wake_o);
    COV_IRQ0: cover property ($rose(ext_irq0_o));
endmodule
bind pxb_port_xbar pxb_props u_props (.sys_clk_i, .reset_n_i,
    .crossbar_enable_bit_i, .pullup_global_disable_i, .pin_input_mode_bits_i,
    .pin_output_style_bits_i, .route_select_reg_a_i, .debug_wire_data_oe_i,
    .ext_irq_pin_config_i, .pad_in_i, .pad_out_o, .pad_oe_o, .pad_pullup_o,
    .pad_rx_en_o, .port_read_o, .periph_assigned_o, .ext_irq0_o, .wake_o);

/* File: dv/tb_top.sv */
// testbench for the port cell and crossbar block
`timescale 1ns/10ps
module tb_top;
    import pxb_pkg::*;
    logic sys_clk_i, reset_n_i, crossbar_enable_bit_i, pullup_global_disable_i;
    logic debug_wire_data_oe_i, debug_wire_data_out_i, debug_wire_data_in_o;
    logic ext_irq0_o, ext_irq1_o, port_match_o, wake_o;
    logic [NPIN-1:0] pin_input_mode_bits_i, pin_output_style_bits_i;
    logic [NPIN-1:0] port_latch_i, pad_in_i, pad_out_o, pad_oe_o;
    logic [NPIN-1:0] pad_pullup_o, pad_rx_en_o, port_read_o, ext_oe, ext_val;
    logic [NSKIP-1:0] pin_skip_bits_i, port_compare_mask_i;
    logic [NSKIP-1:0] port_compare_value_i;
    logic [7:0] route_select_reg_a_i, route_select_reg_b_i;
    logic [7:0] route_select_reg_c_i, ext_irq_pin_config_i;
    logic [NRES-1:0] periph_out_i, periph_drive_i, periph_in_o;
    logic [NRES-1:0] periph_assigned_o;
    int bad_count, checked, pulses;
    pxb_port_xbar DUT (.sys_clk_i, .reset_n_i, .crossbar_enable_bit_i,
        .pullup_global_disable_i, .pin_input_mode_bits_i,
        .pin_output_style_bits_i, .pin_skip_bits_i, .port_latch_i,
        .route_select_reg_a_i, .route_select_reg_b_i, .route_select_reg_c_i,
        .periph_out_i, .periph_drive_i, .debug_wire_data_oe_i,
        .debug_wire_data_out_i, .ext_irq_pin_config_i, .port_compare_mask_i,
        .port_compare_value_i, .pad_in_i, .pad_out_o, .pad_oe_o,
        .pad_pullup_o, .pad_rx_en_o, .port_read_o, .periph_in_o,
        .periph_assigned_o, .debug_wire_data_in_o, .ext_irq0_o, .ext_irq1_o,
        .port_match_o, .wake_o);
    pxb_pad_far FAR (.sys_clk_i(sys_clk_i), .drv_val_i(pad_out_o),
        .drv_en_i(pad_oe_o), .pull_en_i(pad_pullup_o), .ext_en_i(ext_oe),
        .ext_val_i(ext_val), .pad_o(pad_in_i));
    always #2 sys_clk_i = ~sys_clk_i;
    // ==========================================
    // helpers
    task automatic chk(input logic [NPIN-1:0] got, input logic [NPIN-1:0] exp);
        checked++;
        if (got !== exp)
        begin
            bad_count++;
            $display("ERROR %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge sys_clk_i);
        #1;
    endtask
    task automatic summarize();
        $display("checks %0d errors %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // ==========================================
    // scenarios
    initial
    begin
        {sys_clk_i, reset_n_i, crossbar_enable_bit_i} = '0;
        {pullup_global_disable_i, debug_wire_data_oe_i} = '0;
        {debug_wire_data_out_i, pin_output_style_bits_i, port_latch_i} = '0;
        {pin_skip_bits_i, port_compare_mask_i, port_compare_value_i} = '0;
        {route_select_reg_a_i, route_select_reg_b_i} = '0;
        {route_select_reg_c_i, ext_irq_pin_config_i} = '0;
        {periph_out_i, periph_drive_i, ext_oe, ext_val} = '0;
        pin_input_mode_bits_i = '1;
        repeat (12) @(posedge sys_clk_i);
        reset_n_i <= 1;
        wt(3);
        chk(pad_oe_o, '0);
        chk(pad_pullup_o, '1);
        chk(port_read_o, '1);
        @(posedge sys_clk_i);
        pullup_global_disable_i <= 1;
        wt(1);
        chk(pad_pullup_o, '0);
        @(posedge sys_clk_i);
        pullup_global_disable_i <= 0;
        pin_input_mode_bits_i <= ~40'h02_0000_0004;
        ext_oe <= 40'h4;
        ext_val <= 40'h4;
        wt(2);
        chk(40'({pad_rx_en_o[2], pad_pullup_o[2], port_read_o[2]}), '0);
        chk(40'(pad_rx_en_o[33]), 40'h1);
        @(posedge sys_clk_i);
        crossbar_enable_bit_i <= 1;
        pin_skip_bits_i <= '1;
        port_latch_i <= 40'hc00;
        pin_output_style_bits_i <= 40'h01_0000_0410;
        wt(2);
        chk(40'({pad_oe_o[11:9], pad_out_o[10:9], pad_pullup_o[11:9]}),
            40'h76);
        @(posedge sys_clk_i);
        ext_oe <= 40'h804;
        wt(2);
        chk(40'(port_read_o[11:9]), 40'h2);
        @(posedge sys_clk_i);
        pin_skip_bits_i <= ~32'h202;
        route_select_reg_a_i <= 8'h05;
        route_select_reg_c_i <= 8'h01;
        periph_drive_i <= 24'h101;
        periph_out_i <= 24'h1;
        wt(2);
        chk(40'(periph_assigned_o), 40'h30f);
        chk(40'({pad_oe_o[4], pad_out_o[4], pad_oe_o[1], pad_out_o[1], pad_oe_o[9]}), 40'h1c);
        @(posedge sys_clk_i);
        pin_skip_bits_i <= ~32'h2;
        periph_drive_i <= 24'h301;
        periph_out_i <= 24'h001;
        wt(3);
        chk(40'({pad_oe_o[32], pad_out_o[32], pad_oe_o[9], periph_in_o[9]}),
            40'ha);
        @(posedge sys_clk_i);
        debug_wire_data_oe_i <= 1;
        debug_wire_data_out_i <= 1;
        wt(3);
        chk(40'({pad_oe_o[32], pad_out_o[32], debug_wire_data_in_o}),
            40'h7);
        @(posedge sys_clk_i);
        debug_wire_data_oe_i <= 0;
        ext_irq_pin_config_i <= 8'h4b;
        wt(3);
        @(posedge sys_clk_i);
        ext_val <= 40'h804;
        pulses = 0;
        repeat (6)
        begin
            wt(1);
            pulses += int'(wake_o === 1'b1);
        end
        chk(40'(pulses), 40'h1);
        chk(40'({ext_irq0_o, ext_irq1_o}), 40'h3);
        @(posedge sys_clk_i);
        pin_input_mode_bits_i[11] <= 0;
        port_compare_mask_i <= 32'h1000;
        port_compare_value_i <= 32'h1000;
        wt(3);
        chk(40'({ext_irq0_o, port_match_o}), 40'h1);
        @(posedge sys_clk_i);
        port_compare_value_i <= '0;
        wt(3);
        chk(40'(port_match_o), '0);
        summarize();
    end
endmodule
